/* File: dv/timed_serdes_io_port_with_clock_blocks_test.sv */
// Purpose: self-checking bench of the timed port
// Assumes: block 0 paces the port until the block 1 checks, W is 8
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "tsp_map.vh"
module timed_serdes_io_port_with_clock_blocks_test;
	// ****************************************
	// bench
	// ****************************************
	logic clk = 1'b0, resetn = 1'b0, cfg_enable = 1'b0, cfg_dir_out = 1'b0;
	logic cfg_open_drain = 1'b0, cfg_strobe_in_en = 1'b0, cfg_strobe_out_en = 1'b0;
	logic [2:0] cfg_cb_sel = 3'h0;
	logic link_en = 1'b0, cmd_valid = 1'b0, cmd_timed = 1'b0, ext_drive = 1'b0;
	logic ext_strobe = 1'b0, hit;
	logic [5:0] cb_ext_src = 6'h00;
	logic [47:0] cb_div = 48'h0;
	logic ext_clk_pin = 1'b0;
	logic [1:0] cmd_op = 2'h0, cmd_cond = 2'h0;
	logic [7:0] claim_mask = 8'h00, cmd_data = 8'h00, ext_val = 8'h00, d, last, rdata;
	logic [15:0] cmd_time = 16'h0000, t, stamp;
	wire rsp_valid, rsp_hit, evt_pulse, strobe_output, strobe_input, cmd_ready;
	wire [7:0] rsp_data, pin_in, pin_out, pin_oe;
	wire [15:0] rsp_stamp, port_count;
	int miscompares = 0, tests_run = 0, i, k;
	always #10 clk = ~clk;
	tsp_port #(.W(8), .NCB(6)) u_dut (.clk, .resetn, .cfg_enable, .cfg_dir_out,
		.cfg_open_drain, .cfg_strobe_in_en, .cfg_strobe_out_en, .cfg_cb_sel,
		.cb_ext_src, .cb_div, .ext_clk_pin, .link_en, .claim_mask,
		.cmd_valid, .cmd_op, .cmd_data, .cmd_timed, .cmd_time, .cmd_cond, .cmd_ready,
		.rsp_valid, .rsp_hit, .rsp_data, .rsp_stamp, .port_count, .evt_pulse, .pin_in,
		.pin_out, .pin_oe, .strobe_input, .strobe_output);
	tsp_pin_partner #(.W(8)) u_far (.pin_out, .pin_oe, .pin_in, .strobe_input, .ext_val,
		.ext_drive, .ext_strobe);
	function automatic logic [7:0] exp_oe(input logic od, input logic [7:0] v,
		input logic [7:0] m);
		exp_oe = (od ? ~v : 8'hFF) & ~m;
	endfunction
	task automatic summarize;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [1:0] op, input logic [7:0] v, input logic tm,
		input logic [15:0] tv, input logic [1:0] c);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = v;
		cmd_timed = tm;
		cmd_time = tv;
		cmd_cond = c;
		@(negedge clk);
		cmd_valid = 1'b0;
		hit = rsp_hit;
		rdata = rsp_data;
		stamp = rsp_stamp;
		chk(rsp_valid, 16'h1);
	endtask
	// a bound that runs out ends the run as a failure
	task automatic wait_ev(input int n);
		k = 0;
		while (strobe_output !== 1'b1 && evt_pulse !== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > n) begin
				miscompares++;
				summarize();
			end
		end
	endtask
	initial begin
		void'($urandom(32'h12bf67cb));
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		chk(port_count, 16'h0);
		chk(pin_oe, 16'h0);
		cfg_enable = 1'b1;
		cfg_dir_out = 1'b1;
		cfg_strobe_out_en = 1'b1;
		for (i = 0; i < 6; i++) begin
			d = (i < 2) ? {8{i[0]}} : 8'($urandom);
			cfg_open_drain = i[0];
			cmd(`TSP_OP_OUT, d, 1'b0, 16'h0, `TSP_COND_NONE);
			chk(hit, 16'h1);
			wait_ev(8);
			chk(strobe_output, 16'h1);
			chk(pin_oe, exp_oe(i[0], d, 8'h00));
			chk(pin_out, i[0] ? 8'h00 : d);
		end
		cfg_open_drain = 1'b0;
		claim_mask = 8'($urandom);
		repeat (3) @(negedge clk);
		chk(pin_oe, exp_oe(1'b0, d, claim_mask));
		link_en = 1'b1;
		repeat (3) @(negedge clk);
		chk(pin_oe, 16'h0);
		link_en = 1'b0;
		claim_mask = 8'h00;
		cmd(`TSP_OP_CNT, 8'h00, 1'b0, 16'h0, `TSP_COND_NONE);
		t = stamp + 16'd40;
		for (i = 0; i < 5; i++) begin
			d = 8'($urandom);
			cmd(`TSP_OP_OUT, d, i == 0, t, `TSP_COND_NONE);
			chk(hit, i < 4);
			chk(cmd_ready, i < 4);
			if (i < 4) last = d;
		end
		wait_ev(60);
		chk(k > 20, 16'h1);
		repeat (10) @(negedge clk);
		chk(pin_out, last);
		cfg_dir_out = 1'b0;
		ext_drive = 1'b1;
		d = 8'($urandom) | 8'h01;
		cmd(`TSP_OP_OUT, d, 1'b0, 16'h0, `TSP_COND_NONE);
		chk(hit, 16'h0);
		cmd(`TSP_OP_COND, d, 1'b0, 16'h0, `TSP_COND_EQ);
		cmd(`TSP_OP_IN, 8'h00, 1'b0, 16'h0, `TSP_COND_NONE);
		repeat (3) @(negedge clk);
		ext_val = d;
		wait_ev(10);
		chk(k > 0, 16'h1);
		chk(evt_pulse, 16'h1);
		cmd(`TSP_OP_IN, 8'h00, 1'b0, 16'h0, `TSP_COND_NONE);
		chk(hit, 16'h1);
		chk(rdata, d);
		chk(port_count - stamp < 16'd10, 16'h1);
		cfg_strobe_in_en = 1'b1;
		cmd(`TSP_OP_IN, 8'h00, 1'b0, 16'h0, `TSP_COND_NONE);
		ext_val = ~d;
		repeat (5) @(negedge clk);
		cmd(`TSP_OP_IN, 8'h00, 1'b0, 16'h0, `TSP_COND_NONE);
		chk(hit, 16'h0);
		ext_strobe = 1'b1;
		repeat (5) @(negedge clk);
		cmd(`TSP_OP_IN, 8'h00, 1'b0, 16'h0, `TSP_COND_NONE);
		chk(rdata, 8'(~d));
		// block 1 from the tile clock, one tick every four cycles
		cfg_cb_sel = 3'h1;
		cb_div = 48'h300;
		repeat (3) @(negedge clk);
		t = port_count;
		repeat (40) @(negedge clk);
		chk(port_count - t, 16'h000A);
		// block 1 from rising edges of the external clock pin, undivided
		cb_ext_src = 6'h02;
		cb_div = 48'h0;
		repeat (3) @(negedge clk);
		t = port_count;
		for (i = 0; i < 10; i++) begin
			ext_clk_pin = 1'b1;
			repeat (2) @(negedge clk);
			ext_clk_pin = 1'b0;
			repeat (2) @(negedge clk);
		end
		repeat (6) @(negedge clk);
		chk(port_count - t, 16'h000A);
		summarize();
	end
endmodule
`default_nettype wire

/* File: dv/tsp_pin_partner.sv */
// Purpose: external hardware on the port pins
// Assumes: pins carry pull-downs
// Notes: bench chooses the value it drives
`timescale 1ns/1ps
`default_nettype none
module tsp_pin_partner #(parameter W = 8) (
	// port side
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	output logic [W-1:0] pin_in,
	output logic strobe_input,
	// bench side
	input wire logic [W-1:0] ext_val,
	input wire logic ext_drive,
	input wire logic ext_strobe
);
	// ****************************************
	// wire resolution
	// ****************************************
	// a released pin takes ext_val while ext_drive is high, else falls to its pull-down, never keeps the last value
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_drive & ext_val[i]);
		end
	end
	assign strobe_input = ext_strobe;
endmodule
`default_nettype wire

/* File: dv/tsp_port_chk.sv */
// Purpose: checker on the timed port pins and processor answers
// Assumes: W matches the bound port, block 0 selected
// Notes: sees only port signals
`timescale 1ns/1ps
`default_nettype none
`include "tsp_map.vh"
module tsp_port_chk #(parameter W = 8) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// configuration
	input wire logic cfg_enable,
	input wire logic cfg_dir_out,
	input wire logic cfg_open_drain,
	input wire logic cfg_strobe_out_en,
	input wire logic [2:0] cfg_cb_sel,
	input wire logic link_en,
	input wire logic [W-1:0] claim_mask,
	// processor side
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic rsp_valid,
	input wire logic rsp_hit,
	input wire logic [15:0] port_count,
	input wire logic evt_pulse,
	// pins
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic strobe_output
);
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [1:0] up_r;
	// counter history is only trusted a few edges after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	a_rsp_one_late: assert property (cmd_valid |=> rsp_valid)
		else $error("no answer one cycle after request");
	a_rsp_no_cause: assert property (!cmd_valid |=> !rsp_valid)
		else $error("answer without request");
	a_out_refused: assert property (cmd_valid && cmd_op == `TSP_OP_OUT
		&& !(cfg_enable && cfg_dir_out) |=> !rsp_hit)
		else $error("output taken by input or disabled port");
	a_link_pins_off: assert property (link_en && $past(link_en) |-> pin_oe == '0)
		else $error("pin driven under link");
	a_claim_pins_off: assert property ((pin_oe & claim_mask & $past(claim_mask)) == '0)
		else $error("claimed pin driven");
	a_input_no_drive: assert property (!cfg_dir_out && !$past(cfg_dir_out) |-> pin_oe == '0)
		else $error("input port drives pins");
	a_od_never_high: assert property (cfg_open_drain && $past(cfg_open_drain)
		|-> pin_out == '0)
		else $error("open drain drives high");
	a_count_step: assert property (up_r == 2'h3 && cfg_cb_sel == 3'h0 && cfg_enable
		&& $past(cfg_enable) && $past(cfg_enable, 2)
		|-> port_count == $past(port_count) + 16'h1)
		else $error("port counter did not step");
	a_evt_one_cycle: assert property (evt_pulse |=> !evt_pulse)
		else $error("event pulse too long");
	a_strobe_gated: assert property (strobe_output |-> $past(cfg_strobe_out_en))
		else $error("output strobe while disabled");
endmodule
bind tsp_port tsp_port_chk #(.W(W)) u_chk (.clk, .resetn, .cfg_enable, .cfg_dir_out,
	.cfg_open_drain, .cfg_strobe_out_en, .cfg_cb_sel, .link_en, .claim_mask, .cmd_valid,
	.cmd_op, .rsp_valid, .rsp_hit, .port_count, .evt_pulse, .pin_out, .pin_oe,
	.strobe_output);
`default_nettype wire

/* File: logic/tsp_fifo.v */
// Purpose: small flop FIFO with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes: full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
`default_nettype none
module tsp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;
	integer i;

	assign in_ready = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem_r[rd_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_r[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data;
				wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
			end
			if (push & ~pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop & ~push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: logic/tsp_map.vh */
// Purpose: shared constants of the timed serdes I/O port
// Assumes: included by bare name from the port design files
// Notes: definitions only
`ifndef TSP_MAP_VH
`define TSP_MAP_VH
// ****************************************
// widths and counts
// ****************************************
`define TSP_CNT_W 16
`define TSP_NUM_CB 6
`define TSP_CB_SEL_W 3
`define TSP_DIV_W 8
`define TSP_FIFO_DEPTH 4
// ****************************************
// reset values
// ****************************************
`define TSP_CB_RESET 3'h0
`define TSP_CNT_RESET 16'h0000
// ****************************************
// processor port operations
// ****************************************
`define TSP_OP_OUT 2'h0
`define TSP_OP_IN 2'h1
`define TSP_OP_COND 2'h2
`define TSP_OP_CNT 2'h3
// ****************************************
// sampling conditions
// ****************************************
`define TSP_COND_NONE 2'h0
`define TSP_COND_EQ 2'h1
`define TSP_COND_NEQ 2'h2
`endif

/* File: logic/tsp_port.v */
// Purpose: one timed I/O port with transfer register, port counter and clock blocks
// Assumes: clk is the tile clock; pins and the external clock pin are asynchronous
// Notes: width is a parameter; pins are split into in, out and output enable
// Function
// RULE1: ports of 1, 4, 8, 16 or 32 bits, mapped onto pin groups.
// RULE2: every pin of a port shares one direction, all in or all out.
// RULE3: port drives pins high or low, or samples them, optionally waiting a condition.
// RULE4: each processor port operation completes in one processor cycle.
// RULE5: open-drain mode drives low for zero, releases the pin for one.
// RULE6: open-drain is chosen per port, not per pin.
// RULE7: data passes through a serdes buffer and a transfer register.
// RULE8: a 16-bit port counter can time moves to or from the transfer register.
// RULE9: the port counter can be read at any time.
// RULE10: each transfer stores the current counter value as a timestamp.
// RULE11: an enabled link disables the pins of ports underneath it.
// RULE12: an enabled narrower port takes shared pins from wider ports.
// RULE13: unclaimed pins of a wider port remain usable by it.
// RULE14: a port always transfers at its full nominal width.
// RULE15: six clock blocks; block zero is the reference, others programmable.
// RULE16: a clock block may use a 1-bit input pin as source, optionally divided.
// RULE17: ports accept an input strobe and can drive an output strobe with data.
// RULE18: after reset the port runs from clock block zero.
// RULE19: pin events go straight to the scheduler, not through an interrupt.
// RULE20: port counter steps once per governing clock edge, wrapping modulo 65536.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_map.vh"
module tsp_port #(
	parameter W = 8,
	parameter NCB = `TSP_NUM_CB
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// port configuration
	input wire cfg_enable,
	input wire cfg_dir_out,
	input wire cfg_open_drain,
	input wire cfg_strobe_in_en,
	input wire cfg_strobe_out_en,
	input wire [`TSP_CB_SEL_W-1:0] cfg_cb_sel,
	// clock block configuration, one slice per block
	input wire [NCB-1:0] cb_ext_src,
	input wire [NCB*`TSP_DIV_W-1:0] cb_div,
	input wire ext_clk_pin,
	// pin sharing
	input wire link_en,
	input wire [W-1:0] claim_mask,
	// processor operations
	input wire cmd_valid,
	input wire [1:0] cmd_op,
	input wire [W-1:0] cmd_data,
	input wire cmd_timed,
	input wire [`TSP_CNT_W-1:0] cmd_time,
	input wire [1:0] cmd_cond,
	output reg cmd_ready,
	output reg rsp_valid,
	output reg rsp_hit,
	output reg [W-1:0] rsp_data,
	output reg [`TSP_CNT_W-1:0] rsp_stamp,
	// status and events
	output reg [`TSP_CNT_W-1:0] port_count,
	output reg evt_pulse,
	// pins
	input wire [W-1:0] pin_in,
	output reg [W-1:0] pin_out,
	output reg [W-1:0] pin_oe,
	input wire strobe_input,
	output reg strobe_output
);
	localparam FW = W + 1 + `TSP_CNT_W;

	// ****************************************
	// pin synchronisers
	// ****************************************
	reg [W-1:0] pin_s1_r;
	reg [W-1:0] pin_s2_r;
	reg ext_s1_r;
	reg ext_s2_r;
	reg ext_d_r;
	reg stb_s1_r;
	reg stb_s2_r;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1_r <= {W{1'b0}};
			pin_s2_r <= {W{1'b0}};
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_d_r <= 1'b0;
			stb_s1_r <= 1'b0;
			stb_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
			ext_s1_r <= ext_clk_pin;
			ext_s2_r <= ext_s1_r;
			ext_d_r <= ext_s2_r;
			stb_s1_r <= strobe_input;
			stb_s2_r <= stb_s1_r;
		end
	end

	wire ext_rise = ext_s2_r & ~ext_d_r;

	// ****************************************
	// clock blocks
	// ****************************************
	// block zero ticks every tile cycle; a divide of zero passes the source straight
	wire [NCB-1:0] cb_tick;
	genvar g;
	generate
		for (g = 0; g < NCB; g = g + 1) begin : gen_cb
			if (g == 0) begin : gen_ref
				assign cb_tick[g] = 1'b1; // RULE15
			end else begin : gen_prog
				reg [`TSP_DIV_W-1:0] div_cnt_r;
				wire src = cb_ext_src[g] ? ext_rise : 1'b1; // RULE16
				wire [`TSP_DIV_W-1:0] div = cb_div[g*`TSP_DIV_W +: `TSP_DIV_W];
				assign cb_tick[g] = src & (div_cnt_r >= div); // RULE15 RULE16
				always @(posedge clk or negedge resetn) begin
					if (!resetn) begin
						div_cnt_r <= {`TSP_DIV_W{1'b0}};
					end else if (src) begin
						div_cnt_r <= (div_cnt_r >= div) ? {`TSP_DIV_W{1'b0}} :
							div_cnt_r + 1'b1;
					end
				end
			end
		end
	endgenerate

	// a select beyond the last block falls back to the reference block
	wire tick = (cfg_cb_sel < NCB) ? cb_tick[cfg_cb_sel] : cb_tick[0]; // RULE18

	// ****************************************
	// port counter
	// ****************************************
	reg [`TSP_CNT_W-1:0] cnt_r;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= `TSP_CNT_RESET;
		end else if (cfg_enable & tick) begin
			cnt_r <= cnt_r + 1'b1; // RULE20 RULE8
		end
	end

	// ****************************************
	// output buffer
	// ****************************************
	// each entry holds data plus an optional counter value to wait for
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [FW-1:0] fifo_out;
	wire f_timed = fifo_out[W+`TSP_CNT_W];
	wire [`TSP_CNT_W-1:0] f_time = fifo_out[`TSP_CNT_W-1:0];
	wire [W-1:0] f_data = fifo_out[W+`TSP_CNT_W-1:`TSP_CNT_W];
	wire out_push = cmd_valid & (cmd_op == `TSP_OP_OUT) & cfg_dir_out & cfg_enable;
	wire out_move = cfg_enable & cfg_dir_out & tick & fifo_out_valid &
		(~f_timed | (cnt_r == f_time)); // RULE8

	tsp_fifo #(
		.WIDTH(FW),
		.DEPTH(`TSP_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(out_push),
		.in_ready(fifo_in_ready),
		.in_data({cmd_timed, cmd_data, cmd_time}),
		.out_valid(fifo_out_valid),
		.out_ready(out_move),
		.out_data(fifo_out)
	); // RULE7

	// ****************************************
	// input path and condition
	// ****************************************
	reg [W-1:0] xfer_r;
	reg in_full_r;
	reg [1:0] cond_r;
	reg [W-1:0] cond_val_r;
	reg in_timed_r;
	reg [`TSP_CNT_W-1:0] in_time_r;
	reg [`TSP_CNT_W-1:0] stamp_r;

	wire cond_ok = (cond_r == `TSP_COND_NONE) |
		((cond_r == `TSP_COND_EQ) & (pin_s2_r == cond_val_r)) |
		((cond_r == `TSP_COND_NEQ) & (pin_s2_r != cond_val_r)); // RULE3
	wire in_cap = cfg_enable & ~cfg_dir_out & tick & ~in_full_r & cond_ok &
		(~cfg_strobe_in_en | stb_s2_r) &
		(~in_timed_r | (cnt_r == in_time_r)); // RULE3 RULE17 RULE8
	wire in_read = cmd_valid & (cmd_op == `TSP_OP_IN);
	wire cond_set = cmd_valid & (cmd_op == `TSP_OP_COND);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			xfer_r <= {W{1'b0}};
			in_full_r <= 1'b0;
			cond_r <= `TSP_COND_NONE;
			cond_val_r <= {W{1'b0}};
			in_timed_r <= 1'b0;
			in_time_r <= `TSP_CNT_RESET;
			stamp_r <= `TSP_CNT_RESET;
		end else begin
			if (cond_set) begin
				cond_r <= cmd_cond;
				cond_val_r <= cmd_data;
				in_timed_r <= cmd_timed;
				in_time_r <= cmd_time;
			end else if (in_cap) begin
				// a met condition is one-shot, so the pin is not re-matched
				cond_r <= `TSP_COND_NONE;
				in_timed_r <= 1'b0;
			end
			if (in_cap) begin
				xfer_r <= pin_s2_r; // RULE14
				stamp_r <= cnt_r; // RULE10
			end else if (out_move) begin
				xfer_r <= f_data;
				stamp_r <= cnt_r; // RULE10
			end
			// a capture in the same cycle as a read wins, so no sample is lost
			if (in_cap) begin
				in_full_r <= 1'b1;
			end else if (in_read) begin
				in_full_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// processor answers
	// ****************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_hit <= 1'b0;
			rsp_data <= {W{1'b0}};
			rsp_stamp <= `TSP_CNT_RESET;
			port_count <= `TSP_CNT_RESET;
			evt_pulse <= 1'b0;
		end else begin
			cmd_ready <= fifo_in_ready;
			rsp_valid <= cmd_valid; // RULE4
			rsp_hit <= 1'b0;
			port_count <= cnt_r; // RULE9
			evt_pulse <= in_cap & (cond_r != `TSP_COND_NONE); // RULE19
			if (cmd_valid) begin
				case (cmd_op)
					`TSP_OP_OUT: begin
						rsp_hit <= out_push & fifo_in_ready;
						rsp_data <= cmd_data;
						rsp_stamp <= cnt_r;
					end
					`TSP_OP_IN: begin
						rsp_hit <= in_full_r;
						rsp_data <= xfer_r;
						rsp_stamp <= stamp_r; // RULE10
					end
					`TSP_OP_COND: begin
						rsp_hit <= 1'b1;
						rsp_data <= cmd_data;
						rsp_stamp <= cnt_r;
					end
					`TSP_OP_CNT: begin
						rsp_hit <= 1'b1;
						rsp_data <= xfer_r;
						rsp_stamp <= cnt_r; // RULE9
					end
					default: begin
						rsp_hit <= 1'b0;
						rsp_data <= {W{1'b0}};
						rsp_stamp <= cnt_r;
					end
				endcase
			end
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	reg [W-1:0] drive_r;
	wire [W-1:0] own = {W{cfg_enable & cfg_dir_out & ~link_en}} & ~claim_mask; // RULE2 RULE11 RULE12 RULE13
	wire [W-1:0] drive_nxt = out_move ? f_data : drive_r;
	integer k;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive_r <= {W{1'b0}};
			pin_out <= {W{1'b0}};
			pin_oe <= {W{1'b0}};
			strobe_output <= 1'b0;
		end else begin
			drive_r <= drive_nxt;
			strobe_output <= cfg_strobe_out_en & out_move & ~link_en; // RULE17
			for (k = 0; k < W; k = k + 1) begin
				if (cfg_open_drain) begin
					pin_out[k] <= 1'b0; // RULE5 RULE6
					pin_oe[k] <= own[k] & ~drive_nxt[k]; // RULE5 RULE6
				end else begin
					pin_out[k] <= drive_nxt[k]; // RULE3
					pin_oe[k] <= own[k]; // RULE1
				end
			end
		end
	end
endmodule
`default_nettype wire
